// ---- src/cgl_top.v ----
// What this block does
// - Channel-sync-select set uses the channel sync, clear uses a pin.
// - Pin select 00..11 picks external sync input 0..3; ignored when channel sync used.
// - Word length code 000..111 gives 16,12,10,8,7,6,5,4 output bits.
// - Mode zero regulates to desired signal level, one to clipping level.
// - Writing sync-now syncs the stage, emitting a strength sample and restarting.
// - Initialise-on-sync clears CIC and loads decimation, averaging, scale, gain, pole.
// - Every accepted sync emits a CIC update sample and restarts the decimator.
// - First-sync-only lets only the first sync resync; otherwise every sync does.
// - Bypass skips the loop but still truncates to the chosen word length.
// - A sync loads the hold-off counter; sync forwarded when it reaches one.
// - Hold-off value zero means incoming syncs never synchronise the stage.
// - Update decimation ratio is register value plus one, 1 to 4096.
// - Initial gain is 12 bits, 256 codes per 6.02 dB, 0 to 96.296 dB.
// - Error magnitude below threshold uses first loop gain, else the second.
// - CIC scale field in bits 5:2 adds 6.02 dB per step.
// - Averaging field 00..11 combines 1..4 power samples before the CIC: mean in level mode, peak in clipping mode.
// - Pole value 0 to 0.996 loads into the loop only on initialise.
// - Request level is 8 bits, 64 codes per 6.02 dB, per mode.
// - Both loop gains load into use only on initialise, not on write.
`timescale 1ns/1ps
`include "cgl_defs.vh"
module cgl_top (
  // Clock and reset
  input  wire        clk,
  input  wire        rst,
  // Programming port
  input  wire        prog_wr,
  input  wire        prog_rd,
  input  wire [3:0]  prog_addr,
  input  wire [15:0] prog_wdata,
  output reg  [15:0] prog_rdata_ff,
  // Sync sources
  input  wire        chan_sync,
  input  wire        ext_sync_in_0,
  input  wire        ext_sync_in_1,
  input  wire        ext_sync_in_2,
  input  wire        ext_sync_in_3,
  // Samples from the interpolating filter
  input  wire        in_valid,
  input  wire [15:0] in_i,
  input  wire [15:0] in_q,
  output wire        in_ready,
  // Samples to the output ports
  output wire        out_valid,
  output wire [15:0] out_i,
  output wire [15:0] out_q,
  input  wire        out_ready,
  // Signal strength and gain
  output reg         rssi_valid_ff,
  output reg  [11:0] rssi_ff,
  output reg  [11:0] gain_ff
);

  // Software registers
  reg  [10:0] ctrl_ff;
  reg  [15:0] holdoff_ff;
  reg  [11:0] upd_dec_ff;
  reg  [11:0] sgain_ff;
  reg  [11:0] err_thr_ff;
  reg  [5:0]  avg_ff;
  reg  [7:0]  pole_ff;
  reg  [7:0]  req_ff;
  reg  [7:0]  k2_ff;
  reg  [7:0]  k1_ff;

  // Values in use by the loop, loaded only on initialise
  reg  [11:0] act_dec_ff;
  reg  [1:0]  act_avg_ff;
  reg  [3:0]  act_scale_ff;
  reg  [7:0]  act_pole_ff;
  reg  [7:0]  act_k1_ff;
  reg  [7:0]  act_k2_ff;

  // Loop state
  reg         first_done_ff;
  reg  [1:0]  avg_cnt_ff;
  reg  [17:0] avg_sum_ff;
  reg  [15:0] avg_peak_ff;
  reg  [27:0] cic_acc_ff;
  reg  [11:0] dec_cnt_ff;
  reg  signed [15:0] loop_ff;

  wire        byp  = ctrl_ff[`CGL_CTRL_BYP];
  wire        mode = ctrl_ff[`CGL_CTRL_MODE];
  wire [2:0]  wl   = ctrl_ff[`CGL_CTRL_WL_HI:`CGL_CTRL_WL_LO];
  wire [3:0]  ext_sync = {ext_sync_in_3, ext_sync_in_2, ext_sync_in_1, ext_sync_in_0};

  function [15:0] cgl_gain_fn;
    input [15:0] x;
    input [11:0] g;
    reg signed [41:0] p;
    begin
      // Integer part of the log gain shifts, fraction is a linear mantissa
      p = $signed(x) * $signed({2'b01, g[7:0]});
      p = p <<< g[11:8];
      p = p >>> 8;
      if (p > 42'sd32767)
        cgl_gain_fn = 16'h7fff;
      else if (p < -42'sd32768)
        cgl_gain_fn = 16'h8000;
      else
        cgl_gain_fn = p[15:0];
    end
  endfunction

  function [15:0] cgl_trunc_fn;
    input [15:0] x;
    input [2:0]  code;
    begin
      // Kept bits stay MSB aligned so the sample scale does not change
      case (code)
        3'h0:    cgl_trunc_fn = x;
        3'h1:    cgl_trunc_fn = x & 16'hfff0;
        3'h2:    cgl_trunc_fn = x & 16'hffc0;
        3'h3:    cgl_trunc_fn = x & 16'hff00;
        3'h4:    cgl_trunc_fn = x & 16'hfe00;
        3'h5:    cgl_trunc_fn = x & 16'hfc00;
        3'h6:    cgl_trunc_fn = x & 16'hf800;
        default: cgl_trunc_fn = x & 16'hf000;
      endcase
    end
  endfunction

  function [15:0] cgl_abs_fn;
    input [15:0] x;
    begin
      cgl_abs_fn = x[15] ? (~x + 16'h0001) : x;
    end
  endfunction

  // Level below full scale, 256 codes per 6.02 dB
  function [11:0] cgl_log_fn;
    input [15:0] v;
    integer      k;
    reg   [3:0]  m;
    reg   [15:0] s;
    begin
      m = 4'h0;
      for (k = 0; k < 16; k = k + 1) begin
        if (v[k])
          m = k[3:0];
      end
      s = v << (4'hf - m);
      if (v == 16'h0000)
        cgl_log_fn = 12'hfff;
      else
        cgl_log_fn = {4'hf - m, ~s[14:7]};
    end
  endfunction

  // Programming writes
  wire soft_sync = prog_wr && prog_addr == `CGL_OFF_CTRL && prog_wdata[`CGL_CTRL_SNOW];

  always @(posedge clk) begin
    if (rst) begin
      ctrl_ff    <= `CGL_RST_CTRL;
      holdoff_ff <= `CGL_RST_HOLDOFF;
      upd_dec_ff <= `CGL_RST_12;
      sgain_ff   <= `CGL_RST_12;
      err_thr_ff <= `CGL_RST_12;
      avg_ff     <= `CGL_RST_AVG;
      pole_ff    <= `CGL_RST_8;
      req_ff     <= `CGL_RST_8;
      k2_ff      <= `CGL_RST_8;
      k1_ff      <= `CGL_RST_8;
    end else if (prog_wr) begin
      case (prog_addr)
        `CGL_OFF_CTRL:    ctrl_ff    <= prog_wdata[10:0] & 11'h7f7;
        `CGL_OFF_HOLDOFF: holdoff_ff <= prog_wdata;
        `CGL_OFF_UPD_DEC: upd_dec_ff <= prog_wdata[11:0];
        `CGL_OFF_SGAIN:   sgain_ff   <= prog_wdata[11:0];
        `CGL_OFF_ERR_THR: err_thr_ff <= prog_wdata[11:0];
        `CGL_OFF_AVG:     avg_ff     <= prog_wdata[5:0];
        `CGL_OFF_POLE:    pole_ff    <= prog_wdata[7:0];
        `CGL_OFF_REQ:     req_ff     <= prog_wdata[7:0];
        `CGL_OFF_K2:      k2_ff      <= prog_wdata[7:0];
        `CGL_OFF_K1:      k1_ff      <= prog_wdata[7:0];
        default:          ctrl_ff    <= ctrl_ff;
      endcase
    end
  end

  // Programming reads
  always @(posedge clk) begin
    if (rst) begin
      prog_rdata_ff <= 16'h0000;
    end else if (prog_rd) begin
      case (prog_addr)
        `CGL_OFF_CTRL:    prog_rdata_ff <= {5'h00, ctrl_ff};
        `CGL_OFF_HOLDOFF: prog_rdata_ff <= holdoff_ff;
        `CGL_OFF_UPD_DEC: prog_rdata_ff <= {4'h0, upd_dec_ff};
        `CGL_OFF_SGAIN:   prog_rdata_ff <= {4'h0, sgain_ff};
        `CGL_OFF_ERR_THR: prog_rdata_ff <= {4'h0, err_thr_ff};
        `CGL_OFF_AVG:     prog_rdata_ff <= {10'h000, avg_ff};
        `CGL_OFF_POLE:    prog_rdata_ff <= {8'h00, pole_ff};
        `CGL_OFF_REQ:     prog_rdata_ff <= {8'h00, req_ff};
        `CGL_OFF_K2:      prog_rdata_ff <= {8'h00, k2_ff};
        `CGL_OFF_K1:      prog_rdata_ff <= {8'h00, k1_ff};
        `CGL_OFF_RSSI:    prog_rdata_ff <= {4'h0, rssi_ff};
        `CGL_OFF_GAIN:    prog_rdata_ff <= {4'h0, gain_ff};
        default:          prog_rdata_ff <= 16'h0000;
      endcase
    end
  end

  // Sync source and hold-off
  wire pin_sync = ctrl_ff[`CGL_CTRL_CHSEL] ? chan_sync
                : ext_sync[ctrl_ff[`CGL_CTRL_PIN_HI:`CGL_CTRL_PIN_LO]];
  wire hold_fire;

  cgl_holdoff u_holdoff (
    .clk         (clk),
    .rst         (rst),
    .sync_req    (pin_sync | soft_sync),
    .holdoff_val (holdoff_ff),
    .fire_ff     (hold_fire)
  );

  wire sync_go  = hold_fire & ~(ctrl_ff[`CGL_CTRL_FIRST] & first_done_ff);
  wire init_go  = sync_go & ctrl_ff[`CGL_CTRL_INIT];

  // Data path
  wire        samp_go = in_valid & in_ready;
  wire [15:0] proc_i  = byp ? in_i : cgl_gain_fn(in_i, gain_ff);
  wire [15:0] proc_q  = byp ? in_q : cgl_gain_fn(in_q, gain_ff);
  wire [15:0] buf_i;
  wire [15:0] buf_q;

  cgl_buf2 #(.W(32)) u_buf (
    .clk          (clk),
    .rst          (rst),
    .in_valid     (in_valid),
    .in_data      ({cgl_trunc_fn(proc_i, wl), cgl_trunc_fn(proc_q, wl)}),
    .in_ready_ff  (in_ready),
    .out_valid_ff (out_valid),
    .out_data     ({buf_i, buf_q}),
    .out_ready    (out_ready)
  );

  assign out_i = buf_i;
  assign out_q = buf_q;

  // Power detection
  wire [15:0] abs_i = cgl_abs_fn(proc_i);
  wire [15:0] abs_q = cgl_abs_fn(proc_q);
  wire [15:0] mag   = (abs_i > abs_q) ? abs_i : abs_q;

  reg  [17:0] sum_now;
  reg  [15:0] peak_now;
  reg  [25:0] avg_scaled;
  reg  [15:0] avg_val;
  reg  [7:0]  avg_recip;

  always @* begin
    sum_now  = avg_sum_ff + {2'b00, mag};
    peak_now = (mag > avg_peak_ff) ? mag : avg_peak_ff;
    // Multiply by a reciprocal instead of dividing by the 1 to 4 sample count
    case (act_avg_ff)
      2'h0:    avg_recip = 8'hff;
      2'h1:    avg_recip = 8'h80;
      2'h2:    avg_recip = 8'h55;
      default: avg_recip = 8'h40;
    endcase
    avg_scaled = sum_now * avg_recip;
    // Clipping mode tracks peaks, level mode tracks the mean
    avg_val = mode ? peak_now : avg_scaled[23:8];
  end

  wire        avg_done = samp_go & ~byp & (avg_cnt_ff == act_avg_ff);
  wire        dec_done = avg_done & (dec_cnt_ff == act_dec_ff);
  wire        upd_go   = dec_done | sync_go;
  wire [27:0] cic_now  = avg_done ? cic_acc_ff + {12'h000, avg_val} : cic_acc_ff;
  wire [27:0] cic_sc   = cic_now >> act_scale_ff;
  wire [15:0] cic_out  = (cic_sc[27:16] != 12'h000) ? 16'hffff : cic_sc[15:0];
  wire [11:0] meas     = cgl_log_fn(cic_out);

  // Loop filter
  reg  signed [31:0] err;
  reg  signed [31:0] err_mag;
  reg  signed [31:0] loop_step;
  reg  signed [31:0] gain_sum;
  reg  [11:0]        nxt_gain;
  reg  [15:0]        nxt_loop;

  always @* begin
    err       = $signed({20'h00000, meas}) - $signed({22'h00000, req_ff, 2'b00});
    err_mag   = err[31] ? -err : err;
    loop_step = (($signed({16'h0000, loop_ff}) * $signed({24'h000000, act_pole_ff})) >>> 8)
              + ((err * $signed({24'h000000,
                  (err_mag < $signed({20'h00000, err_thr_ff})) ? act_k1_ff : act_k2_ff})) >>> 8);
    if (loop_ff[15])
      loop_step = loop_step - (($signed({16'h0000, loop_ff}) * $signed({24'h000000, act_pole_ff})) >>> 8)
                + (($signed({{16{1'b1}}, loop_ff}) * $signed({24'h000000, act_pole_ff})) >>> 8);
    if (loop_step > 32'sd32767)
      loop_step = 32'sd32767;
    else if (loop_step < -32'sd32768)
      loop_step = -32'sd32768;
    nxt_loop = loop_step[15:0];
    gain_sum = $signed({20'h00000, gain_ff}) + loop_step;
    // Gain stays within the 0 to 96 dB span
    if (gain_sum < 32'sd0)
      nxt_gain = 12'h000;
    else if (gain_sum > 32'sd4095)
      nxt_gain = 12'hfff;
    else
      nxt_gain = gain_sum[11:0];
  end

  // Loop sequencing
  always @(posedge clk) begin
    if (rst) begin
      act_dec_ff    <= `CGL_RST_12;
      act_avg_ff    <= 2'h0;
      act_scale_ff  <= 4'h0;
      act_pole_ff   <= `CGL_RST_8;
      act_k1_ff     <= `CGL_RST_8;
      act_k2_ff     <= `CGL_RST_8;
      gain_ff       <= `CGL_RST_12;
      loop_ff       <= 16'sh0000;
      first_done_ff <= 1'b0;
      avg_cnt_ff    <= 2'h0;
      avg_sum_ff    <= 18'h00000;
      avg_peak_ff   <= 16'h0000;
      cic_acc_ff    <= 28'h0000000;
      dec_cnt_ff    <= 12'h000;
      rssi_valid_ff <= 1'b0;
      rssi_ff       <= 12'hfff;
    end else begin
      rssi_valid_ff <= upd_go;
      if (sync_go)
        first_done_ff <= 1'b1;
      if (samp_go && !byp) begin
        if (avg_done) begin
          avg_cnt_ff  <= 2'h0;
          avg_sum_ff  <= 18'h00000;
          avg_peak_ff <= 16'h0000;
        end else begin
          avg_cnt_ff  <= avg_cnt_ff + 2'h1;
          avg_sum_ff  <= sum_now;
          avg_peak_ff <= peak_now;
        end
      end
      if (avg_done)
        dec_cnt_ff <= dec_cnt_ff + 12'h001;
      cic_acc_ff <= cic_now;
      if (upd_go) begin
        rssi_ff    <= meas;
        dec_cnt_ff <= 12'h000;
        // Without initialise a sync keeps the running sum
        if (dec_done)
          cic_acc_ff <= 28'h0000000;
        if (!byp) begin
          gain_ff <= nxt_gain;
          loop_ff <= nxt_loop;
        end
      end
      if (init_go) begin
        act_dec_ff   <= upd_dec_ff;
        act_avg_ff   <= avg_ff[`CGL_AVG_N_HI:`CGL_AVG_N_LO];
        act_scale_ff <= avg_ff[`CGL_AVG_SC_HI:`CGL_AVG_SC_LO];
        act_pole_ff  <= pole_ff;
        act_k1_ff    <= k1_ff;
        act_k2_ff    <= k2_ff;
        gain_ff      <= sgain_ff;
        loop_ff      <= 16'sh0000;
        cic_acc_ff   <= 28'h0000000;
        avg_cnt_ff   <= 2'h0;
        avg_sum_ff   <= 18'h00000;
        avg_peak_ff  <= 16'h0000;
      end
    end
  end

endmodule

// ---- include/cgl_defs.vh ----
`ifndef CGL_DEFS_VH
`define CGL_DEFS_VH

// Programming port offsets
`define CGL_OFF_CTRL     4'h0
`define CGL_OFF_HOLDOFF  4'h1
`define CGL_OFF_UPD_DEC  4'h2
`define CGL_OFF_SGAIN    4'h3
`define CGL_OFF_ERR_THR  4'h4
`define CGL_OFF_AVG      4'h5
`define CGL_OFF_POLE     4'h6
`define CGL_OFF_REQ      4'h7
`define CGL_OFF_K2       4'h8
`define CGL_OFF_K1       4'h9
`define CGL_OFF_RSSI     4'ha
`define CGL_OFF_GAIN     4'hb

// Control field positions
`define CGL_CTRL_CHSEL   10
`define CGL_CTRL_PIN_HI  9
`define CGL_CTRL_PIN_LO  8
`define CGL_CTRL_WL_HI   7
`define CGL_CTRL_WL_LO   5
`define CGL_CTRL_MODE    4
`define CGL_CTRL_SNOW    3
`define CGL_CTRL_INIT    2
`define CGL_CTRL_FIRST   1
`define CGL_CTRL_BYP     0

// Averaging register fields
`define CGL_AVG_SC_HI    5
`define CGL_AVG_SC_LO    2
`define CGL_AVG_N_HI     1
`define CGL_AVG_N_LO     0

// Reset values
`define CGL_RST_CTRL     11'h000
`define CGL_RST_HOLDOFF  16'h0001
`define CGL_RST_12       12'h000
`define CGL_RST_8        8'h00
`define CGL_RST_AVG      6'h00

`endif

// ---- src/cgl_holdoff.v ----
`timescale 1ns/1ps
module cgl_holdoff (
  // Clock and reset
  input  wire        clk,
  input  wire        rst,
  // Sync request and count
  input  wire        sync_req,
  input  wire [15:0] holdoff_val,
  // Forwarded sync
  output reg         fire_ff
);

  reg  [15:0] cnt_ff;

  always @(posedge clk) begin
    if (rst) begin
      cnt_ff  <= 16'h0000;
      fire_ff <= 1'b0;
    end else begin
      fire_ff <= 1'b0;
      if (sync_req) begin
        // A new request restarts any countdown in flight
        if (holdoff_val == 16'h0001) begin
          fire_ff <= 1'b1;
          cnt_ff  <= 16'h0000;
        end else begin
          cnt_ff  <= holdoff_val;
        end
      end else if (cnt_ff > 16'h0001) begin
        if (cnt_ff == 16'h0002) begin
          fire_ff <= 1'b1;
          cnt_ff  <= 16'h0000;
        end else begin
          cnt_ff  <= cnt_ff - 16'h0001;
        end
      end
    end
  end

endmodule

// ---- src/cgl_buf2.v ----
`timescale 1ns/1ps
module cgl_buf2 #(
  parameter W = 32
) (
  // Clock and reset
  input  wire         clk,
  input  wire         rst,
  // Fill side
  input  wire         in_valid,
  input  wire [W-1:0] in_data,
  output reg          in_ready_ff,
  // Drain side
  output reg          out_valid_ff,
  output wire [W-1:0] out_data,
  input  wire         out_ready
);

  reg  [W-1:0] mem_ff [0:1];
  reg  [1:0]   cnt_ff;
  reg  [1:0]   nxt_cnt;
  wire         push = in_valid & in_ready_ff;
  wire         pop  = out_valid_ff & out_ready;
  wire [1:0]   wr_idx = pop ? cnt_ff - 2'd1 : cnt_ff;

  assign out_data = mem_ff[0];

  always @* begin
    nxt_cnt = cnt_ff + {1'b0, push} - {1'b0, pop};
  end

  always @(posedge clk) begin
    if (rst) begin
      cnt_ff       <= 2'd0;
      in_ready_ff  <= 1'b0;
      out_valid_ff <= 1'b0;
      mem_ff[0]    <= {W{1'b0}};
      mem_ff[1]    <= {W{1'b0}};
    end else begin
      cnt_ff       <= nxt_cnt;
      in_ready_ff  <= (nxt_cnt != 2'd2);
      out_valid_ff <= (nxt_cnt != 2'd0);
      if (pop)
        mem_ff[0] <= mem_ff[1];
      // Later write wins when the slot just vacated is refilled
      if (push && wr_idx == 2'd0)
        mem_ff[0] <= in_data;
      if (push && wr_idx == 2'd1)
        mem_ff[1] <= in_data;
    end
  end

endmodule

// ---- dv/cgl_checker.sv ----
`timescale 1ns/1ps
module cgl_checker (
  // Clock and reset
  input wire        clk,
  input wire        rst,
  // Programming port
  input wire        prog_wr,
  input wire        prog_rd,
  input wire [3:0]  prog_addr,
  input wire [15:0] prog_wdata,
  input wire [15:0] prog_rdata_ff,
  // Sample stream
  input wire        in_valid,
  input wire        in_ready,
  input wire        out_valid,
  input wire [15:0] out_i,
  input wire [15:0] out_q,
  input wire        out_ready,
  // Strength and gain
  input wire        rssi_valid_ff,
  input wire [11:0] rssi_ff,
  input wire [11:0] gain_ff
);
  reg [10:0] ctl_ff;
  reg [15:0] hold_ff;
  reg [11:0] sg_ff;
  reg [1:0]  cnt_ff;

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  // Shadows of written registers and a count of buffered words, so outputs can be tied to what was programmed and sent
  always @(posedge clk) begin
    if (rst) begin
      ctl_ff  <= 11'h000;
      hold_ff <= 16'h0001;
      sg_ff   <= 12'h000;
      cnt_ff  <= 2'h0;
    end else begin
      if (prog_wr && prog_addr == 4'h0) ctl_ff <= prog_wdata[10:0];
      if (prog_wr && prog_addr == 4'h1) hold_ff <= prog_wdata;
      if (prog_wr && prog_addr == 4'h3) sg_ff <= prog_wdata[11:0];
      cnt_ff <= cnt_ff + (in_valid && in_ready) - (out_valid && out_ready);
    end
  end

  function automatic [15:0] wmask(input [2:0] c);
    case (c)
      3'h0: wmask = 16'hffff;
      3'h1: wmask = 16'hfff0;
      3'h2: wmask = 16'hffc0;
      3'h3: wmask = 16'hff00;
      3'h4: wmask = 16'hfe00;
      3'h5: wmask = 16'hfc00;
      3'h6: wmask = 16'hf800;
      default: wmask = 16'hf000;
    endcase
  endfunction

  sequence soft_sync;
    prog_wr && prog_addr == 4'h0 && prog_wdata[3] && !prog_wdata[1] && hold_ff == 16'h0001;
  endsequence
  sequence init_sync;
    soft_sync ##0 (prog_wdata[2] && !prog_wdata[0]);
  endsequence

  a_rst_outputs: assert property (@(posedge clk) disable iff (1'b0) rst |=> !in_ready && !out_valid
    && !rssi_valid_ff && gain_ff == 12'h000 && rssi_ff == 12'hfff) else $error("reset state wrong");
  a_soft_sync_pulse: assert property (soft_sync |-> ##2 rssi_valid_ff)
    else $error("soft sync gave no strength pulse");
  a_init_gain_load: assert property (init_sync |-> ##2 gain_ff == sg_ff)
    else $error("initial gain not loaded");
  a_out_trunc_bits: assert property (out_valid |-> ((out_i | out_q) & ~wmask(ctl_ff[7:5])) == 16'h0000)
    else $error("output not truncated");
  a_out_hold_data: assert property (out_valid && !out_ready |=> out_valid && $stable(out_i) && $stable(out_q))
    else $error("output word not held");
  a_ready_tracks_fill: assert property (!$past(rst) |-> in_ready == (cnt_ff != 2'h2))
    else $error("input ready wrong for fill");
  a_valid_tracks_fill: assert property (!$past(rst) |-> out_valid == (cnt_ff != 2'h0))
    else $error("output valid wrong for fill");
  a_rdata_hold_value: assert property (!prog_rd |=> $stable(prog_rdata_ff))
    else $error("read data changed without read");
  a_unmapped_read_zero: assert property (prog_rd && prog_addr > 4'hb |=> prog_rdata_ff == 16'h0000)
    else $error("unmapped read not zero");
  a_sync_now_zero: assert property (prog_rd && prog_addr == 4'h0 |=> prog_rdata_ff[15:11] == 5'h00
    && !prog_rdata_ff[3]) else $error("control read back wrong");
endmodule

// ---- dv/cgl_far_model.sv ----
`timescale 1ns/1ps
module cgl_far_model (
  // Clock
  input wire        clk,
  // Sample source side
  output reg        in_valid,
  output reg [15:0] in_i,
  output reg [15:0] in_q,
  input wire        in_ready,
  // Sample sink side
  input wire        out_valid,
  input wire [15:0] out_i,
  input wire [15:0] out_q,
  output reg        out_ready,
  // Bench control
  input wire        stall
);
  logic [15:0] tx_q[$];
  logic [31:0] rx_q[$];
  logic [15:0] w;
  reg          took_ff;

  initial begin
    in_valid = 1'b0;
    in_i = 16'h0000;
    in_q = 16'h0000;
    out_ready = 1'b0;
    took_ff = 1'b0;
  end

  always @(posedge clk) begin
    took_ff <= in_valid && in_ready;
    if (out_valid && out_ready) rx_q.push_back({out_i, out_q});
  end

  // Word held until taken; idle lines toggle so a stale value never looks valid
  always @(negedge clk) begin
    out_ready <= !stall;
    if (!in_valid || took_ff) begin
      if (tx_q.size() > 0) begin
        w = tx_q.pop_front();
        in_valid <= 1'b1;
        in_i <= w;
        in_q <= {w[7:0], w[15:8]};
      end else begin
        in_valid <= 1'b0;
        in_i <= ~in_i;
        in_q <= ~in_q;
      end
    end
  end
endmodule

// ---- dv/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
  logic clk = 0, rst = 1, prog_wr = 0, prog_rd = 0, chan_sync = 0, stall = 0;
  logic [3:0]  prog_addr = 4'h0, pin = 4'h0;
  logic [15:0] prog_wdata = 16'h0000;
  logic [10:0] ctl = 11'h000;
  wire         in_valid, in_ready, out_valid, out_ready, rssi_valid_ff;
  wire [15:0]  in_i, in_q, out_i, out_q, prog_rdata_ff;
  wire [11:0]  rssi_ff, gain_ff;
  int          err_count = 0, checks = 0, cyc = 0;
  int          wl[8] = '{16, 12, 10, 8, 7, 6, 5, 4};
  logic [15:0] pat[10] = '{16'h07f7, 16'h0009, 16'h0abc, 16'h0fff, 16'h0123,
                           16'h003f, 16'h00a5, 16'h005a, 16'h00c3, 16'h003c};

  always #20 clk = ~clk;

  cgl_top i_dut (.clk(clk), .rst(rst), .prog_wr(prog_wr), .prog_rd(prog_rd), .prog_addr(prog_addr),
    .prog_wdata(prog_wdata), .prog_rdata_ff(prog_rdata_ff), .chan_sync(chan_sync),
    .ext_sync_in_0(pin[0]), .ext_sync_in_1(pin[1]), .ext_sync_in_2(pin[2]), .ext_sync_in_3(pin[3]),
    .in_valid(in_valid), .in_i(in_i), .in_q(in_q), .in_ready(in_ready), .out_valid(out_valid),
    .out_i(out_i), .out_q(out_q), .out_ready(out_ready), .rssi_valid_ff(rssi_valid_ff),
    .rssi_ff(rssi_ff), .gain_ff(gain_ff));

  cgl_far_model i_far (.clk(clk), .in_valid(in_valid), .in_i(in_i), .in_q(in_q), .in_ready(in_ready),
    .out_valid(out_valid), .out_i(out_i), .out_q(out_q), .out_ready(out_ready), .stall(stall));

  task stop_test;
    if (err_count == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task chk(input logic [15:0] seen, input logic [15:0] exp, input string nm);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task wr(input logic [3:0] a, input logic [15:0] d);
    @(negedge clk);
    prog_wr = 1;
    prog_addr = a;
    prog_wdata = d;
    @(negedge clk);
    prog_wr = 0;
  endtask

  task rd(input logic [3:0] a, input logic [15:0] exp);
    @(negedge clk);
    prog_rd = 1;
    prog_addr = a;
    @(negedge clk);
    prog_rd = 0;
    chk(prog_rdata_ff, exp, "read data");
  endtask

  // Source 0 is the sync-now bit, 1 the channel sync, 2..5 the pins; exp 0 means no pulse
  task automatic sync_chk(input int src, input int exp, input string nm);
    int got;
    got = 0;
    @(negedge clk);
    if (src == 0) begin
      prog_wr = 1;
      prog_addr = 4'h0;
      prog_wdata = {5'h00, ctl | 11'h008};
    end else if (src == 1) chan_sync = 1;
    else pin[src-2] = 1;
    @(negedge clk);
    prog_wr = 0;
    chan_sync = 0;
    pin = 4'h0;
    for (int c = 1; c <= 12 && got == 0; c++) begin
      @(posedge clk);
      #1;
      if (rssi_valid_ff === 1'b1) got = c;
    end
    chk(got[15:0], exp[15:0], nm);
  endtask

  task automatic t_regs;
    for (int a = 0; a < 12; a++) rd(a[3:0], (a == 1) ? 16'h0001 : (a == 10) ? 16'h0fff : 16'h0000);
    rd(4'hc, 16'h0000);
    for (int a = 0; a < 10; a++) begin
      wr(a[3:0], pat[a]);
      rd(a[3:0], pat[a]);
    end
    for (int a = 0; a < 10; a++) wr(a[3:0], (a == 1) ? 16'h0001 : 16'h0000);
  endtask

  task automatic t_sync;
    int n[3] = '{1, 2, 5};
    for (int k = 0; k < 3; k++) begin
      wr(4'h1, n[k][15:0]);
      sync_chk(0, n[k], "sync delay");
    end
    wr(4'h1, 16'h0000);
    sync_chk(0, 0, "zero hold-off");
    wr(4'h1, 16'h0006);
    wr(4'h0, {5'h00, ctl | 11'h008});
    sync_chk(0, 6, "restart");
    wr(4'h1, 16'h0001);
    for (int k = 0; k < 4; k++) begin
      ctl = {1'b0, k[1:0], 8'h00};
      wr(4'h0, {5'h00, ctl});
      sync_chk(2 + (k + 1) % 4, 0, "other pin");
      sync_chk(2 + k, 1, "chosen pin");
    end
    sync_chk(1, 0, "chan unused");
    ctl = 11'h700;
    wr(4'h0, {5'h00, ctl});
    sync_chk(1, 1, "chan sync");
    sync_chk(5, 0, "pin unused");
  endtask

  task automatic t_init;
    wr(4'h3, 16'h04c3);
    ctl = 11'h014;
    sync_chk(0, 1, "init sync");
    chk({4'h0, gain_ff}, 16'h04c3, "init gain");
    rd(4'hb, 16'h04c3);
    wr(4'h3, 16'h0111);
    ctl = 11'h000;
    sync_chk(0, 1, "plain sync");
    chk({4'h0, gain_ff}, 16'h04c3, "kept gain");
    ctl = 11'h001;
    sync_chk(0, 1, "bypass sync");
    chk({4'h0, gain_ff}, 16'h04c3, "frozen gain");
  endtask

  task automatic t_wl;
    logic [15:0] m, w;
    logic [31:0] r;
    w = 16'hb6d9;
    for (int c = 0; c < 8; c++) begin
      m = 16'hffff << (16 - wl[c]);
      ctl = {3'h0, c[2:0], 5'h01};
      wr(4'h0, {5'h00, ctl});
      i_far.tx_q.push_back(w);
      repeat (6) @(negedge clk);
      chk(16'(i_far.rx_q.size()), 16'h0001, "word count");
      r = i_far.rx_q.pop_front();
      chk(r[31:16], w & m, "out i");
      chk(r[15:0], {w[7:0], w[15:8]} & m, "out q");
    end
  endtask

  // Sink stalls while the source keeps offering, so the buffer must refuse the third word
  task automatic t_buf;
    ctl = 11'h001;
    wr(4'h0, {5'h00, ctl});
    stall = 1;
    for (int k = 0; k < 4; k++) i_far.tx_q.push_back(16'h1000 + k[15:0]);
    repeat (8) @(negedge clk);
    chk({15'h0000, in_ready}, 16'h0000, "full ready");
    chk(16'(i_far.tx_q.size()), 16'h0001, "words held");
    stall = 0;
    repeat (10) @(negedge clk);
    chk(16'(i_far.rx_q.size()), 16'h0004, "drained");
    for (int k = 0; k < 4; k++) chk(i_far.rx_q[k][31:16], 16'h1000 + k[15:0], "order");
    chk({15'h0000, out_valid}, 16'h0000, "empty");
  endtask

  task automatic t_first;
    @(negedge clk);
    rst = 1;
    repeat (2) @(negedge clk);
    rst = 0;
    ctl = 11'h002;
    sync_chk(0, 1, "first sync");
    sync_chk(0, 0, "later sync");
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      stop_test;
    end
  end

  initial begin
    repeat (10) @(posedge clk);
    @(negedge clk);
    rst = 0;
    t_regs;
    t_sync;
    t_init;
    t_wl;
    t_buf;
    t_first;
    stop_test;
  end
endmodule

bind cgl_top cgl_checker u_chk (.clk(clk), .rst(rst), .prog_wr(prog_wr), .prog_rd(prog_rd),
  .prog_addr(prog_addr), .prog_wdata(prog_wdata), .prog_rdata_ff(prog_rdata_ff), .in_valid(in_valid),
  .in_ready(in_ready), .out_valid(out_valid), .out_i(out_i), .out_q(out_q), .out_ready(out_ready),
  .rssi_valid_ff(rssi_valid_ff), .rssi_ff(rssi_ff), .gain_ff(gain_ff));
